/* logic/pmtr_pkg.sv */
// Purpose: Shared constants and types for the program memory table reader
// Assumes: 32-bit AXI4-Lite register bus, 16-bit program words
// Notes:   Register offsets are byte addresses on the bus
package pmtr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PTR_LOW   = 8'h00;  // fetch_pointer_low
  localparam logic [7:0] OFS_PTR_HIGH  = 8'h04;  // fetch_pointer_high
  localparam logic [7:0] OFS_PTR_UPPER = 8'h08;  // fetch_pointer_upper
  localparam logic [7:0] OFS_LATCH     = 8'h0C;  // fetched_byte_latch
  localparam logic [7:0] OFS_OP        = 8'h10;  // operation command
  localparam logic [7:0] OFS_STATUS    = 8'h14;  // busy status

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int         PTR_W         = 22;     // Full pointer width
  localparam int         PTR_LOW_W     = 21;     // Auto-update span
  localparam int         UPPER_USED_W  = 6;      // Used bits of upper reg
  localparam int         WORD_ADDR_W   = 20;     // Word address: byte span minus bit 0
  localparam logic [7:0] RST_BYTE      = 8'h00;  // Register reset value
  localparam int         OP_STORE_BIT  = 2;      // Command bit: store op
  localparam int         BUSY_BIT      = 0;      // Status bit: busy

  // ---------------------------------------------------------------
  // Timing: a fetch takes two busy cycles, a store only one
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_CYCLES     = 2'h2;

  // Pointer behaviour for a fetch
  typedef enum logic [1:0] {
    PMTR_PTR_KEEP    = 2'b00,
    PMTR_PTR_POSTINC = 2'b01,
    PMTR_PTR_POSTDEC = 2'b10,
    PMTR_PTR_PREINC  = 2'b11
  } pmtr_ptr_mode_t;

  // Request toward the program memory
  typedef struct packed {
    logic                   req;   // Word read request
    logic                   cfg;   // Configuration-space select
    logic                   lsb;   // High byte wanted when set
    logic [WORD_ADDR_W-1:0] addr;  // Word address
  } pmtr_mem_req_t;

endpackage

/* logic/pmtr_table_reader.sv */
// Purpose: Byte-wide table reader from 16-bit program memory to 8-bit space
// Assumes: Program memory word is valid while the request stands
// Notes:   Registers reached over AXI4-Lite; one command at a time
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps

module pmtr_table_reader
  import pmtr_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset_n,
  // AXI4-Lite write address
  input  wire logic [7:0]             i_awaddr,
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  // AXI4-Lite write response
  output logic [1:0]                  o_bresp,
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]             i_araddr,
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  // AXI4-Lite read data
  output logic [31:0]                 o_rdata,
  output logic [1:0]                  o_rresp,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  // Program memory word port
  output pmtr_mem_req_t               o_mem,
  input  wire logic [15:0]            i_mem_word
);

  // ---------------------------------------------------------------
  // Local types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,      // Waiting for a command
    ST_FETCH,     // Word requested, capture byte next
    ST_STORE      // Store op burns its second cycle
  } pmtr_state_t;

  // Map a byte address onto a register slot
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    unique case (a)
      OFS_PTR_LOW:   reg_sel = 3'h1;
      OFS_PTR_HIGH:  reg_sel = 3'h2;
      OFS_PTR_UPPER: reg_sel = 3'h3;
      OFS_LATCH:     reg_sel = 3'h4;
      OFS_OP:        reg_sel = 3'h5;
      OFS_STATUS:    reg_sel = 3'h6;
      default:       reg_sel = 3'h0;  // Unmapped
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [PTR_W-1:0]  ptr;             // Byte pointer
  logic [PTR_W-1:0]  next_ptr;
  logic [7:0]        latch;           // Fetched byte latch
  logic [7:0]        next_latch;
  pmtr_state_t       state;
  pmtr_state_t       next_state;
  pmtr_ptr_mode_t    mode;            // Mode of command in flight
  pmtr_ptr_mode_t    next_mode;
  pmtr_mem_req_t     mem;             // Registered memory request
  pmtr_mem_req_t     next_mem;
  logic              aw_held;         // Address taken, waiting for data
  logic              next_aw_held;
  logic [7:0]        aw_addr;         // Captured write address
  logic [7:0]        next_aw_addr;
  logic              w_held;          // Data taken, waiting for address
  logic              next_w_held;
  logic [31:0]       w_data;          // Captured write data
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;          // Captured byte enables
  logic [3:0]        next_w_strb;
  logic              bvalid;
  logic              next_bvalid;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;
  logic              rvalid;
  logic              next_rvalid;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;
  logic              aw_rdy;          // Write address ready, registered
  logic              next_aw_rdy;
  logic              w_rdy;           // Write data ready, registered
  logic              next_w_rdy;
  logic              ar_rdy;          // Read address ready, registered
  logic              next_ar_rdy;

  // Combinational helpers
  logic              do_write;        // Both halves of a write present
  logic [2:0]        wsel;            // Decoded write slot
  logic [PTR_W-1:0]  upd_ptr;         // Pointer after inc/dec
  logic [PTR_W-1:0]  fetch_ptr;       // Pointer used for this read

  // ---------------------------------------------------------------
  // Pointer arithmetic
  // ---------------------------------------------------------------
  // Carry never reaches the config-space bit, so an increment past the
  // top of program space wraps within it rather than escaping.
  always_comb begin
    upd_ptr = ptr;
    unique case (mode)
      PMTR_PTR_POSTDEC: begin
        upd_ptr = {ptr[PTR_W-1], ptr[PTR_LOW_W-1:0] - 21'h0_0001};
      end
      PMTR_PTR_KEEP: begin
        upd_ptr = ptr;
      end
      default: begin
        upd_ptr = {ptr[PTR_W-1], ptr[PTR_LOW_W-1:0] + 21'h0_0001};
      end
    endcase
  end

  // Pre-increment reads with the already-updated pointer
  always_comb begin
    fetch_ptr = (mode == PMTR_PTR_PREINC) ? upd_ptr : ptr;
  end

  // ---------------------------------------------------------------
  // Write channel acceptance
  // ---------------------------------------------------------------
  // Each half is held until its partner arrives; a new write waits
  // until the previous response is taken.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    if (o_awready && i_awvalid) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (o_wready && i_wvalid) begin
      next_w_held = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
  end

  // Held halves wait while a fetch or store is busy, so nothing is lost
  assign do_write = aw_held && w_held && !bvalid && (state == ST_IDLE);
  assign wsel     = reg_sel(aw_addr);

  // ---------------------------------------------------------------
  // Register writes, command engine and memory request
  // ---------------------------------------------------------------
  always_comb begin
    next_ptr    = ptr;
    next_latch  = latch;
    next_state  = state;
    next_mode   = mode;
    next_mem    = '0;
    next_bvalid = bvalid;
    next_bresp  = bresp;
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        if (do_write) begin
          next_bvalid = 1'b1;
          next_bresp  = (wsel == 3'h0 || wsel == 3'h6) ? 2'b10 : 2'b00;
          if (wsel == 3'h1 && w_strb[0]) begin
            next_ptr[7:0] = w_data[7:0];
          end
          if (wsel == 3'h2 && w_strb[0]) begin
            next_ptr[15:8] = w_data[7:0];
          end
          if (wsel == 3'h3 && w_strb[0]) begin
            next_ptr[21:16] = w_data[UPPER_USED_W-1:0];
          end
          if (wsel == 3'h4 && w_strb[0]) begin
            next_latch = w_data[7:0];
          end
          if (wsel == 3'h5 && w_strb[0]) begin
            if (w_data[OP_STORE_BIT]) begin
              next_state = ST_STORE;
            end else begin
              next_state = ST_FETCH;
              next_mode  = pmtr_ptr_mode_t'(w_data[1:0]);
            end
          end
        end
      end
      ST_FETCH: begin
        // Cycle one: issue the word read with all pointer bits
        next_mem.req  = 1'b1;
        next_mem.cfg  = fetch_ptr[PTR_W-1];
        next_mem.lsb  = fetch_ptr[0];
        next_mem.addr = fetch_ptr[PTR_LOW_W-1:1];
        next_ptr      = (mode == PMTR_PTR_KEEP) ? ptr : upd_ptr;
        next_state    = ST_IDLE;
      end
      ST_STORE: begin
        // Second cycle of a store: nothing changes
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Cycle two: exactly one byte of the returned word lands in the latch
    if (mem.req) begin
      next_latch = mem.lsb ? i_mem_word[15:8] : i_mem_word[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (o_arready && i_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      unique case (reg_sel(i_araddr))
        3'h1:    next_rdata = {24'h00_0000, ptr[7:0]};
        3'h2:    next_rdata = {24'h00_0000, ptr[15:8]};
        3'h3:    next_rdata = {26'h00_0000, ptr[21:16]};
        3'h4:    next_rdata = {24'h00_0000, latch};
        3'h5:    next_rdata = {30'h000_0000, mode};
        3'h6:    next_rdata = {31'h000_0000, state != ST_IDLE || mem.req};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'b10;  // Unmapped address
        end
      endcase
    end
  end

  // Readies follow the next held and valid state, so each is a flop
  always_comb begin
    next_aw_rdy = !next_aw_held && !next_bvalid;
    next_w_rdy  = !next_w_held && !next_bvalid;
    next_ar_rdy = !next_rvalid;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ptr     <= '0;
      latch   <= RST_BYTE;
      state   <= ST_IDLE;
      mode    <= PMTR_PTR_KEEP;
      mem     <= '0;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'b00;
      aw_rdy  <= 1'b1;
      w_rdy   <= 1'b1;
      ar_rdy  <= 1'b1;
    end else begin
      ptr     <= next_ptr;
      latch   <= next_latch;
      state   <= next_state;
      mode    <= next_mode;
      mem     <= next_mem;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      aw_rdy  <= next_aw_rdy;
      w_rdy   <= next_w_rdy;
      ar_rdy  <= next_ar_rdy;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Ready signals are flop-derived; one write and one read at a time
  assign o_awready = aw_rdy;
  assign o_wready  = w_rdy;
  assign o_arready = ar_rdy;
  assign o_bvalid  = bvalid;
  assign o_bresp   = bresp;
  assign o_rvalid  = rvalid;
  assign o_rdata   = rdata;
  assign o_rresp   = rresp;
  assign o_mem     = mem;

endmodule

/* verif/pmtr_table_reader_chk.sv */
// Purpose: Port-level checks for the table reader
// Assumes: Bound into every pmtr_table_reader instance
// Notes:   Watches bus handshakes and memory requests only
`timescale 1ns/1ps
module pmtr_table_reader_chk
  import pmtr_pkg::*;
(
  input wire logic          i_clk_sys,
  input wire logic          i_reset_n,
  input wire logic          i_awvalid,
  input wire logic          o_awready,
  input wire logic          o_wready,
  input wire logic [1:0]    o_bresp,
  input wire logic          o_bvalid,
  input wire logic          i_bready,
  input wire logic          i_arvalid,
  input wire logic          o_arready,
  input wire logic [31:0]   o_rdata,
  input wire logic          o_rvalid,
  input wire logic          i_rready,
  input wire pmtr_mem_req_t o_mem
);
  // ---------------------------------------------------------------
  // One clock domain, so shared clocking
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  // Read address accepted
  sequence s_ar_taken;
    i_arvalid && o_arready;
  endsequence

  // Write answer followed by the memory request
  sequence s_wr_then_req;
    o_bvalid ##1 o_mem.req;
  endsequence

  a_reset_clear: assert property ($rose(i_reset_n) |-> !o_bvalid && !o_rvalid && !o_mem.req)
    else $error("outputs not idle after reset");
  a_one_request: assert property (o_mem.req |=> !o_mem.req)
    else $error("memory request wider than one cycle");
  a_fetch_time: assert property (o_mem.req |-> $past(o_bvalid))
    else $error("memory request not one cycle after write answer");
  a_read_answer: assert property (s_ar_taken |=> o_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped before taken");
  a_aw_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while answer pending");
  a_ar_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while answer pending");
  c_fetch: cover property (s_wr_then_req);
endmodule

bind pmtr_table_reader pmtr_table_reader_chk u_pmtr_table_reader_chk (
  .i_clk_sys, .i_reset_n, .i_awvalid, .o_awready, .o_wready, .o_bresp, .o_bvalid,
  .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_mem
);

/* verif/pmtr_mem_model.sv */
// Purpose: Program memory word model behind the table reader
// Assumes: Word wanted while the request stands
// Notes:   Output toggles when idle so stale words cannot pass
`timescale 1ns/1ps
module pmtr_mem_model
  import pmtr_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire pmtr_mem_req_t i_mem,
  output logic [15:0]        o_mem_word
);
  // Idle filler flips each cycle so a stale word cannot pass
  logic [15:0] idle_word = 16'h0000;

  always @(posedge i_clk_sys) begin
    idle_word <= ~idle_word;
  end

  // Word is a pattern of the word address; top byte marks config space.
  // The reader samples it while its request stands, so it is driven at once.
  always_comb begin
    o_mem_word = idle_word;
    if (i_mem.req) begin
      o_mem_word = {i_mem.addr[7:0] ^ {i_mem.cfg, 7'h00}, ~i_mem.addr[7:0]};
    end
  end
endmodule

/* verif/pmtr_table_reader_bench.sv */
// Purpose: Register-level test of the table reader
// Assumes: Memory model answers while the request stands
// Notes:   Expected bytes come from the bench's own pattern
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module pmtr_table_reader_bench
  import pmtr_pkg::*;
;
  // ---------------------------------------------------------------
  // Design connections
  // ---------------------------------------------------------------
  logic          i_clk_sys = 1'b0;
  logic          i_reset_n = 1'b0;
  logic [7:0]    i_awaddr  = 8'h00;
  logic          i_awvalid = 1'b0;
  logic [31:0]   i_wdata   = 32'h0000_0000;
  logic [3:0]    i_wstrb   = 4'hF;
  logic          i_wvalid  = 1'b0;
  logic          i_bready  = 1'b0;
  logic [7:0]    i_araddr  = 8'h00;
  logic          i_arvalid = 1'b0;
  logic          i_rready  = 1'b0;
  logic          o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]    o_bresp, o_rresp;
  logic [31:0]   o_rdata;
  pmtr_mem_req_t o_mem;
  logic [15:0]   i_mem_word;
  int            num_errors = 0;
  int            cmp_count  = 0;
  int            cyc        = 0;
  logic [21:0]   ptr;
  logic [7:0]    lat;
  logic [31:0]   d;
  logic [1:0]    r;
  logic [1:0]    modes [6] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};

  always #10 i_clk_sys = ~i_clk_sys;

  pmtr_table_reader u_pmtr_table_reader (
    .i_clk_sys, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_mem, .i_mem_word
  );
  pmtr_mem_model u_pmtr_mem_model (.i_clk_sys, .i_mem(o_mem), .o_mem_word(i_mem_word));

  // ---------------------------------------------------------------
  // Bus tasks: each ends one edge late so no signal is set twice per step
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    i_awaddr  <= a;
    i_wdata   <= v;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    rs = o_bresp;
    i_bready <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    v  = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // Byte the memory pattern holds at byte address p
  function automatic logic [7:0] eb(input logic [21:0] p);
    logic [15:0] w;
    w = {p[8:1] ^ {p[21], 7'h00}, ~p[8:1]};
    return p[0] ? w[15:8] : w[7:0];
  endfunction

  task automatic setp(input logic [21:0] p);
    logic [1:0] rs;
    ptr = p;
    wr(OFS_PTR_LOW, {24'h00_0000, p[7:0]}, rs);
    wr(OFS_PTR_HIGH, {24'h00_0000, p[15:8]}, rs);
    wr(OFS_PTR_UPPER, {26'h00_0000, p[21:16]}, rs);
  endtask

  task automatic chk_ptr(input logic [21:0] p);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(OFS_PTR_LOW, v, rs);
    `CHK(v, {24'h00_0000, p[7:0]})
    rd(OFS_PTR_HIGH, v, rs);
    `CHK(v, {24'h00_0000, p[15:8]})
    rd(OFS_PTR_UPPER, v, rs);
    `CHK(v, {26'h00_0000, p[21:16]})
  endtask

  // One fetch; carry and borrow stay inside the low span
  task automatic fetch(input logic [1:0] m);
    logic [31:0] v;
    logic [1:0]  rs;
    logic [21:0] q;
    q = {ptr[21], (m == PMTR_PTR_POSTDEC) ? ptr[20:0] - 21'h1 : ptr[20:0] + 21'h1};
    lat = eb((m == PMTR_PTR_PREINC) ? q : ptr);
    wr(OFS_OP, {30'h000_0000, m}, rs);
    rd(OFS_STATUS, v, rs);
    `CHK(v[BUSY_BIT], 1'b0)
    rd(OFS_LATCH, v, rs);
    `CHK(v, {24'h00_0000, lat})
    if (m != PMTR_PTR_KEEP) ptr = q;
    chk_ptr(ptr);
  endtask

  task automatic stop_test();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard well above the few hundred cycles needed
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(OFS_LATCH, d, r);
    `CHK(d, 32'h0000_0000)
    chk_ptr(22'h00_0000);
    wr(OFS_PTR_UPPER, 32'h0000_00FF, r);
    rd(OFS_PTR_UPPER, d, r);
    `CHK(d, 32'h0000_003F)
    // Config space, wrap at the span top, odd addresses
    setp(22'h3F_FFFF);
    foreach (modes[i]) fetch(modes[i]);
    setp(22'h01_2345);
    fetch(2'h2);
    fetch(2'h3);
    // Store op must leave pointer and latch alone
    wr(OFS_OP, 32'h0000_0005, r);
    rd(OFS_LATCH, d, r);
    `CHK(d, {24'h00_0000, lat})
    chk_ptr(ptr);
    wr(OFS_LATCH, 32'h0000_00A5, r);
    rd(OFS_LATCH, d, r);
    `CHK(d, 32'h0000_00A5)
    // Unmapped read and read-only status write are refused
    rd(8'h18, d, r);
    `CHK({r, d}, {2'b10, 32'h0000_0000})
    wr(OFS_STATUS, 32'h0000_0001, r);
    `CHK(r, 2'b10)
    // Mid-run reset must clear a pointer and latch left non-zero
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(OFS_LATCH, d, r);
    `CHK(d, 32'h0000_0000)
    chk_ptr(22'h00_0000);
    stop_test();
  end
endmodule
